//--- include/esc_pkg.sv
// constants for the execution-sample capture bank: register indices,
// field positions, write masks, reset values and the sampling phases.
// assumes a 64-bit model-specific register port on the core side.

package esc_pkg;

	// ==============================================================
	// register indices on the model-specific register port
	localparam logic [2:0] IDX_CONTROL = 3'h0;
	localparam logic [2:0] IDX_MEMSYS = 3'h1;
	localparam logic [2:0] IDX_DCACHE = 3'h2;
	localparam logic [2:0] IDX_LINEAR = 3'h3;
	localparam logic [2:0] IDX_PHYS = 3'h4;
	localparam logic [2:0] IDX_BRANCH = 3'h5;

	// ==============================================================
	// dcache_sample_info field positions
	localparam int DC_LAT_LSB = 32;
	localparam int DC_PHYS_VALID = 18;
	localparam int DC_LIN_VALID = 17;
	localparam int DC_LOCKED = 15;
	localparam int DC_UNCACHEABLE = 14;
	localparam int DC_WRITE_COMB = 13;
	localparam int DC_MISALIGNED = 8;
	localparam int DC_MISS = 7;
	localparam int DC_TLB_1G = 5;
	localparam int DC_TLB_2M = 4;
	localparam int DC_TLB_MISS = 2;
	localparam int DC_STORE = 1;
	localparam int DC_LOAD = 0;
	localparam logic [63:0] DC_WRITE_MASK = 64'h0000_FFFF_0006_E1B7;

	// ==============================================================
	// op_sample_control field positions
	localparam int CTL_CUR_LSB = 32;
	localparam int CTL_MAX_HI_LSB = 20;
	localparam int CTL_CNT_CTL = 19;
	localparam int CTL_VALID = 18;
	localparam int CTL_ENABLE = 17;
	localparam logic [63:0] CTL_WRITE_MASK = 64'h07FF_FFFF_07FE_FFFF;

	// ==============================================================
	// widths, counter layout and reset values
	localparam int CNT_W = 27;
	localparam int CNT_CMP_LSB = 4;
	localparam int CNT_KEEP_LSB = 7;
	localparam int LAT_W = 16;
	localparam int PHYS_W = 52;
	localparam logic [63:0] RESET_WORD = 64'h0000_0000_0000_0000;
	localparam logic [15:0] LAT_MAX = 16'hFFFF;
	localparam logic [6:0] RND_SEED = 7'h5A;

	// gray-coded sampling phases along idle, count, tagged, publish
	typedef enum logic [1:0] {
		ESC_IDLE = 2'b00,
		ESC_COUNT = 2'b01,
		ESC_TAGGED = 2'b11,
		ESC_PUBLISH = 2'b10
	} esc_phase_e;

endpackage

//--- hw/esc_lfsr.sv
// free-running pseudo-random source for the interval counter low bits.
// assumes one clock and a synchronous active-low reset.

`timescale 1ns/10ps

module esc_lfsr #(
	parameter int W = 7
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	output logic [W-1:0] rnd_value
);

	typedef struct packed {
		logic [W-1:0] lfsr;
	} esc_lfsr_s;

	esc_lfsr_s st_r;
	esc_lfsr_s st_nxt;

	// x^7 + x^6 + 1; never reaches all-zero because the seed is nonzero
	always_comb begin
		st_nxt = st_r;
		st_nxt.lfsr = {st_r.lfsr[W-2:0], st_r.lfsr[W-1] ^ st_r.lfsr[W-2]};
	end

	// ==============================================================
	// state register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_r.lfsr <= W'(esc_pkg::RND_SEED);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rnd_value = st_r.lfsr;

endmodule

//--- hw/esc_capture.sv
// execution-sample capture bank: tags one op, gathers its data-cache,
// address and branch results, and publishes them to software.
// assumes the load/store unit reports each access portion of the tagged
// op and the pipeline reports retire or abort once per tagged op.

`timescale 1ns/10ps

module esc_capture #(
	parameter int RND_W = 7
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	// model-specific register port
	input wire logic msr_rd,
	input wire logic msr_wr,
	input wire logic [2:0] msr_idx,
	input wire logic [63:0] msr_wdata,
	output logic [63:0] msr_rdata,
	// op selection
	input wire logic op_dispatched,
	output logic tag_req,
	// access report from the load/store unit
	input wire logic acc_valid,
	input wire logic acc_upper,
	input wire logic acc_load,
	input wire logic acc_store,
	input wire logic acc_locked,
	input wire logic acc_uncacheable,
	input wire logic acc_write_comb,
	input wire logic acc_misaligned,
	input wire logic acc_dc_miss,
	input wire logic acc_tlb_1g,
	input wire logic acc_tlb_2m,
	input wire logic acc_tlb_miss,
	input wire logic acc_lin_valid,
	input wire logic [63:0] acc_lin_addr,
	input wire logic acc_phys_valid,
	input wire logic [51:0] acc_phys_addr,
	// miss latency markers for the tagged access
	input wire logic lat_miss_detect,
	input wire logic lat_data_deliver,
	// retire or abort of the tagged op
	input wire logic op_retire,
	input wire logic op_abort,
	input wire logic [63:0] br_target,
	input wire logic br_cond_not_taken,
	input wire logic [63:0] br_fallthrough,
	input wire logic [63:0] memsys_data,
	output logic sample_irq
);

	// ==============================================================
	// all state lives in one struct: published registers, the staged
	// copy of the tagged access, the miss timer and the output flops.
	// staging keeps half-finished results away from software, so a read
	// racing the retire never mixes two samples
	typedef struct packed {
		esc_pkg::esc_phase_e phase;
		logic en;
		logic cnt_ctl;
		logic valid;
		logic [22:0] max_cnt;
		logic [26:0] cnt;
		logic [63:0] memsys;
		logic [63:0] dcache;
		logic [63:0] linear;
		logic [63:0] phys;
		logic [63:0] branch;
		logic [63:0] stage_dc;
		logic [63:0] stage_lin;
		logic [63:0] stage_phys;
		logic lat_busy;
		logic [15:0] lat_cnt;
		logic [63:0] rdata;
		logic irq;
		logic tag;
	} esc_state_s;

	esc_state_s st_r;
	esc_state_s st_nxt;
	logic [RND_W-1:0] rnd_value;

	// ==============================================================
	// random source for the abort reload of the low counter bits
	// the source runs freely, so the reload depends on when the abort
	// lands; that is enough to spread the sample points
	esc_lfsr #(
		.W(RND_W)
	) u_rnd (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.rnd_value(rnd_value)
	);

	// ==============================================================
	// register read decode; unmapped indices read as zero
	// reads are registered so msr_rdata comes from a flip-flop; the
	// cost is one cycle of read latency
	function automatic logic [63:0] esc_read(
		input logic [2:0] idx,
		input esc_state_s s
	);
		logic [63:0] w;
		w = esc_pkg::RESET_WORD;
		// unused control bits read as zero
		if (idx == esc_pkg::IDX_CONTROL) begin
			w = {5'h00, s.cnt, 5'h00, s.max_cnt[22:16], s.cnt_ctl, s.valid,
				s.en, 1'b0, s.max_cnt[15:0]};
		end else if (idx == esc_pkg::IDX_MEMSYS) begin
			w = s.memsys;
		end else if (idx == esc_pkg::IDX_DCACHE) begin
			w = s.dcache;
		end else if (idx == esc_pkg::IDX_LINEAR) begin
			w = s.linear;
		end else if (idx == esc_pkg::IDX_PHYS) begin
			w = s.phys;
		end else if (idx == esc_pkg::IDX_BRANCH) begin
			w = s.branch;
		end
		return w;
	endfunction

	// ==============================================================
	// fold one access report into a staged cache word
	// reserved bits keep their old value, which is zero after the tag
	function automatic logic [63:0] esc_dc_flags(
		input logic [63:0] old
	);
		logic [63:0] w;
		w = old;
		w[esc_pkg::DC_LOAD] = acc_load;
		w[esc_pkg::DC_STORE] = acc_store;
		w[esc_pkg::DC_LOCKED] = acc_locked;
		w[esc_pkg::DC_UNCACHEABLE] = acc_uncacheable;
		w[esc_pkg::DC_WRITE_COMB] = acc_write_comb;
		w[esc_pkg::DC_MISALIGNED] = acc_misaligned;
		w[esc_pkg::DC_MISS] = acc_dc_miss;
		w[esc_pkg::DC_TLB_1G] = acc_tlb_1g;
		w[esc_pkg::DC_TLB_2M] = acc_tlb_2m;
		w[esc_pkg::DC_TLB_MISS] = acc_tlb_miss;
		w[esc_pkg::DC_LIN_VALID] = acc_lin_valid;
		w[esc_pkg::DC_PHYS_VALID] = acc_phys_valid;
		return w;
	endfunction

	// ==============================================================
	// next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		st_nxt.tag = 1'b0;
		st_nxt.rdata = esc_pkg::RESET_WORD;

		// reads answer on the next edge; other cycles show zero
		if (msr_rd) begin
			st_nxt.rdata = esc_read(msr_idx, st_r);
		end

		// software writes first so hardware updates below win a collision
		// write masks keep reserved bits at zero; an unmapped index falls
		// through every branch and changes nothing
		if (msr_wr) begin
			if (msr_idx == esc_pkg::IDX_CONTROL) begin
				st_nxt.en = msr_wdata[esc_pkg::CTL_ENABLE];
				st_nxt.cnt_ctl = msr_wdata[esc_pkg::CTL_CNT_CTL];
				st_nxt.valid = msr_wdata[esc_pkg::CTL_VALID];
				st_nxt.max_cnt = {msr_wdata[26:esc_pkg::CTL_MAX_HI_LSB],
					msr_wdata[15:0]};
				st_nxt.cnt = msr_wdata[58:esc_pkg::CTL_CUR_LSB];
			end else if (msr_idx == esc_pkg::IDX_MEMSYS) begin
				st_nxt.memsys = msr_wdata;
			end else if (msr_idx == esc_pkg::IDX_DCACHE) begin
				st_nxt.dcache = msr_wdata & esc_pkg::DC_WRITE_MASK;
			end else if (msr_idx == esc_pkg::IDX_LINEAR) begin
				st_nxt.linear = msr_wdata;
			end else if (msr_idx == esc_pkg::IDX_PHYS) begin
				st_nxt.phys = {12'h000, msr_wdata[51:0]};
			end else if (msr_idx == esc_pkg::IDX_BRANCH) begin
				st_nxt.branch = msr_wdata;
			end
		end

		// interval counter runs only while sampling with no sample held
		// freezing it keeps the count readable as the point of the sample
		if ((st_r.phase == esc_pkg::ESC_COUNT ||
			st_r.phase == esc_pkg::ESC_TAGGED) && !st_r.valid) begin
			if (!st_r.cnt_ctl || op_dispatched) begin
				st_nxt.cnt = st_r.cnt + 27'h0000001;
			end
		end

		// miss latency: counts from detection until delivery, saturating
		// saturation keeps a very long miss from wrapping to a small value
		if (st_r.lat_busy) begin
			if (st_r.lat_cnt != esc_pkg::LAT_MAX) begin
				st_nxt.lat_cnt = st_r.lat_cnt + 16'h0001;
			end
			if (lat_data_deliver) begin
				st_nxt.lat_busy = 1'b0;
			end
		end

		// ==============================================================
		// sampling phases: idle, count, tagged, publish; an abort drops
		// back to count without touching the published registers
		case (st_r.phase)
		esc_pkg::ESC_IDLE: begin
			// leaves idle only when enabled with no sample pending
			if (st_r.en && !st_r.valid) begin
				st_nxt.phase = esc_pkg::ESC_COUNT;
			end
		end
		esc_pkg::ESC_COUNT: begin
			// a disable or a held sample parks the machine in idle
			if (!st_r.en || st_r.valid) begin
				st_nxt.phase = esc_pkg::ESC_IDLE;
			end else if (st_r.cnt[26:esc_pkg::CNT_CMP_LSB] == st_r.max_cnt)
			begin
				// the next op is tagged; staging starts clean
				st_nxt.tag = 1'b1;
				st_nxt.phase = esc_pkg::ESC_TAGGED;
				st_nxt.stage_dc = esc_pkg::RESET_WORD;
				st_nxt.stage_lin = esc_pkg::RESET_WORD;
				st_nxt.stage_phys = esc_pkg::RESET_WORD;
				st_nxt.lat_busy = 1'b0;
				st_nxt.lat_cnt = 16'h0000;
			end
		end
		esc_pkg::ESC_TAGGED: begin
			// upper portions of a split access are dropped on purpose
			if (acc_valid && !acc_upper) begin
				st_nxt.stage_dc = esc_dc_flags(st_r.stage_dc);
				st_nxt.stage_lin = acc_lin_addr;
				st_nxt.stage_phys = {12'h000, acc_phys_addr};
			end
			// the miss timer only starts for the lower portion
			if (lat_miss_detect && !acc_upper) begin
				st_nxt.lat_busy = 1'b1;
				st_nxt.lat_cnt = 16'h0000;
			end
			if (op_abort) begin
				// no sample; counter restarts from a random low offset
				st_nxt.cnt = 27'(rnd_value);
				st_nxt.lat_busy = 1'b0;
				st_nxt.phase = esc_pkg::ESC_COUNT;
			end else if (op_retire) begin
				// data lands one edge ahead of the valid bit
				st_nxt.dcache = st_nxt.stage_dc;
				// a store has no meaningful latency, so the field reads zero
				if (st_nxt.stage_dc[esc_pkg::DC_STORE]) begin
					st_nxt.dcache[47:esc_pkg::DC_LAT_LSB] = 16'h0000;
				end else begin
					st_nxt.dcache[47:esc_pkg::DC_LAT_LSB] = st_nxt.lat_cnt;
				end
				st_nxt.linear = st_nxt.stage_lin;
				st_nxt.phys = st_nxt.stage_phys;
				st_nxt.memsys = memsys_data;
				if (br_cond_not_taken) begin
					st_nxt.branch = br_fallthrough;
				end else begin
					st_nxt.branch = br_target;
				end
				st_nxt.lat_busy = 1'b0;
				st_nxt.phase = esc_pkg::ESC_PUBLISH;
			end
		end
		esc_pkg::ESC_PUBLISH: begin
			// publish sits one edge behind the data commit, so no register
			// is seen half-updated once valid reads as set
			// set wins over a software clear landing in this cycle
			st_nxt.valid = 1'b1;
			st_nxt.irq = 1'b1;
			st_nxt.cnt = st_r.cnt;
			st_nxt.phase = esc_pkg::ESC_IDLE;
		end
		// unused encodings recover to idle
		default: begin
			st_nxt.phase = esc_pkg::ESC_IDLE;
		end
		endcase
	end

	// ==============================================================
	// state register
	// synchronous reset clears every field to its idle value
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_r.phase <= esc_pkg::ESC_IDLE;
			st_r.en <= 1'b0;
			st_r.cnt_ctl <= 1'b0;
			st_r.valid <= 1'b0;
			st_r.max_cnt <= 23'h000000;
			st_r.cnt <= 27'h0000000;
			st_r.memsys <= esc_pkg::RESET_WORD;
			st_r.dcache <= esc_pkg::RESET_WORD;
			st_r.linear <= esc_pkg::RESET_WORD;
			st_r.phys <= esc_pkg::RESET_WORD;
			st_r.branch <= esc_pkg::RESET_WORD;
			st_r.stage_dc <= esc_pkg::RESET_WORD;
			st_r.stage_lin <= esc_pkg::RESET_WORD;
			st_r.stage_phys <= esc_pkg::RESET_WORD;
			st_r.lat_busy <= 1'b0;
			st_r.lat_cnt <= 16'h0000;
			st_r.rdata <= esc_pkg::RESET_WORD;
			st_r.irq <= 1'b0;
			st_r.tag <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==============================================================
	// outputs straight from the state register
	// no combinational path from any input reaches a port
	assign msr_rdata = st_r.rdata;
	assign tag_req = st_r.tag;
	assign sample_irq = st_r.irq;

endmodule

//--- sim/esc_capture_checker.sv
// checker for the capture bank, bound onto its top module.
// assumes one retire or abort from the core for each tag.
`timescale 1ns/10ps
module esc_capture_checker #(
	parameter int RND_W = 7
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic msr_rd,
	input wire logic [2:0] msr_idx,
	input wire logic [63:0] msr_rdata,
	input wire logic tag_req,
	input wire logic op_retire,
	input wire logic op_abort,
	input wire logic sample_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ========
	// helper: an op is in flight from its tag to its retire or abort
	logic tg_r;
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			tg_r <= 1'b0;
		else if (tag_req)
			tg_r <= 1'b1;
		else if (op_retire || op_abort)
			tg_r <= 1'b0;
	end
	// ========
	// publish, interrupt and abort
	a_irq_after_retire:
		assert property (tg_r && op_retire && !op_abort |-> ##2 sample_irq)
		else $error("no interrupt after retire");
	a_irq_one_cycle:
		assert property (sample_irq |=> !sample_irq)
		else $error("interrupt longer than one cycle");
	a_irq_has_cause:
		assert property (sample_irq |-> $past(tg_r, 2) && $past(op_retire, 2))
		else $error("interrupt without a retired op");
	a_abort_no_irq:
		assert property (op_abort |=> !sample_irq [*2])
		else $error("interrupt after abort");
	a_one_tag:
		assert property (tg_r |-> !tag_req)
		else $error("second tag while op in flight");
	// ========
	// register read-back fields
	a_phys_top_zero:
		assert property (msr_rd && msr_idx == esc_pkg::IDX_PHYS
			|=> msr_rdata[63:52] == 12'h000)
		else $error("physical address top bits set");
	a_dcache_reserved:
		assert property (msr_rd && msr_idx == esc_pkg::IDX_DCACHE
			|=> (msr_rdata & ~esc_pkg::DC_WRITE_MASK) == 64'h0)
		else $error("reserved cache bits set");
	a_store_no_lat:
		assert property (msr_rd && msr_idx == esc_pkg::IDX_DCACHE
			##1 msr_rdata[esc_pkg::DC_STORE] |-> msr_rdata[47:32] == 16'h0)
		else $error("latency on a store");
endmodule
bind esc_capture esc_capture_checker #(.RND_W(RND_W)) esc_capture_checker_i (
	.ref_clk, .rst_n, .msr_rd, .msr_idx, .msr_rdata, .tag_req,
	.op_retire, .op_abort, .sample_irq
);

//--- sim/esc_core_model.sv
// model of the core pipeline and load/store unit.
// assumes one clock; answers each tag with lower and upper accesses.
`timescale 1ns/10ps
module esc_core_model (
	input wire logic ref_clk,
	input wire logic tag_req,
	input wire logic slow,
	input wire logic do_abort,
	output logic [11:0] fl,
	output logic acc_upper,
	output logic acc_valid,
	output logic miss_det,
	output logic deliver,
	output logic retire,
	output logic abort,
	output logic [63:0] lin,
	output logic [51:0] phys,
	output logic [63:0] tgt,
	output logic not_taken,
	output logic [63:0] fall,
	output logic [63:0] ms
);
	// ========
	// payload changes every cycle: only strobed values carry meaning
	always @(posedge ref_clk) begin
		#1;
		fl = 12'($urandom);
		lin = {$urandom, $urandom};
		phys = 52'({$urandom, $urandom});
		tgt = ($urandom % 4 == 0) ? 64'h0 : {$urandom, $urandom};
		not_taken = 1'($urandom);
		fall = {$urandom, $urandom};
		ms = {$urandom, $urandom};
	end
	task automatic step(input logic [3:0] s);
		@(posedge ref_clk) #1 {acc_upper, acc_valid, miss_det, deliver} = s;
	endtask
	// ========
	// per tag: lower access, miss timing, upper access, end of op
	initial begin
		logic ab;
		{acc_upper, acc_valid, miss_det, deliver, retire, abort} = 6'h00;
		forever begin
			@(posedge ref_clk);
			if (tag_req === 1'b1) begin
				ab = do_abort;
				step(4'h4);
				step(4'h2);
				repeat (slow ? 9 : 2) step(4'h0);
				step(4'h1);
				step(4'hC);
				step(4'h0);
				@(posedge ref_clk) #1 {retire, abort} = {!ab, ab};
				@(posedge ref_clk) #1 {retire, abort} = 2'h0;
			end
		end
	end
endmodule

//--- sim/exec_sample_dcache_branch_capture_bench.sv
// self-checking bench for the capture bank with a core-side model.
// assumes the checker is bound onto the design from its own file.
`timescale 1ns/10ps
module exec_sample_dcache_branch_capture_bench;
	logic ref_clk, rst_n, msr_rd, msr_wr, op_dispatched, tag_req, sample_irq;
	logic acc_valid, acc_upper, miss_det, deliver, retire, abort;
	logic not_taken, slow, do_abort;
	logic tg = 1'b0;
	logic [2:0] msr_idx, ev;
	logic [11:0] fl, sfl;
	logic [15:0] slat;
	logic [51:0] phys, sphys;
	logic [63:0] msr_wdata, msr_rdata, lin, tgt, fall, ms, d, v, w, slin;
	logic [63:0] exp_r [0:7];
	int errors, checks, cyc, t0, n;
	int pos [12] = '{0, 1, 15, 14, 13, 8, 7, 5, 4, 2, 17, 18};
	assign ev = {abort, sample_irq, tag_req};
	esc_capture esc_capture_i (
		.ref_clk, .rst_n, .msr_rd, .msr_wr, .msr_idx, .msr_wdata, .msr_rdata,
		.op_dispatched, .tag_req, .acc_valid, .acc_upper,
		.acc_load(fl[0]), .acc_store(fl[1]), .acc_locked(fl[2]),
		.acc_uncacheable(fl[3]), .acc_write_comb(fl[4]),
		.acc_misaligned(fl[5]), .acc_dc_miss(fl[6]), .acc_tlb_1g(fl[7]),
		.acc_tlb_2m(fl[8]), .acc_tlb_miss(fl[9]), .acc_lin_valid(fl[10]),
		.acc_phys_valid(fl[11]), .acc_lin_addr(lin), .acc_phys_addr(phys),
		.lat_miss_detect(miss_det), .lat_data_deliver(deliver),
		.op_retire(retire), .op_abort(abort), .br_target(tgt),
		.br_cond_not_taken(not_taken), .br_fallthrough(fall),
		.memsys_data(ms), .sample_irq
	);
	esc_core_model esc_core_model_i (
		.ref_clk, .tag_req, .slow, .do_abort, .fl, .acc_upper, .acc_valid,
		.miss_det, .deliver, .retire, .abort, .lin, .phys, .tgt, .not_taken,
		.fall, .ms
	);
	// ========
	// clock and a random dispatch stream
	initial ref_clk = 1'b0;
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) #1 op_dispatched = 1'($urandom);
	// ========
	// reference model: stages the lower access, commits on retire only
	always @(posedge ref_clk) begin
		cyc++;
		if (tag_req === 1'b1) begin
			tg = 1'b1;
			sfl = 12'h0;
			slat = 16'h0;
		end
		if (tg && acc_valid && !acc_upper) begin
			sfl = fl;
			slin = lin;
			sphys = phys;
		end
		if (tg && miss_det && !acc_upper)
			t0 = cyc;
		if (tg && deliver)
			slat = 16'(cyc - t0);
		if (tg && retire && !abort) begin
			w = 64'h0;
			for (int i = 0; i < 12; i++)
				w[pos[i]] = sfl[i];
			if (!sfl[1])
				w[47:32] = slat;
			exp_r[1] = ms;
			exp_r[2] = w;
			exp_r[3] = slin;
			exp_r[4] = {12'h000, sphys};
			exp_r[5] = not_taken ? fall : tgt;
		end
		if (retire || abort)
			tg = 1'b0;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] want);
		checks++;
		if (seen !== want) begin
			errors++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [2:0] i, input logic [63:0] val);
		@(posedge ref_clk) #1 msr_wr = 1'b1;
		msr_idx = i;
		msr_wdata = val;
		@(posedge ref_clk) #1 msr_wr = 1'b0;
	endtask
	task automatic rd(input logic [2:0] i);
		@(posedge ref_clk) #1 msr_rd = 1'b1;
		msr_idx = i;
		@(posedge ref_clk) #1 msr_rd = 1'b0;
		d = msr_rdata;
	endtask
	// bounded wait: 0 tag, 1 interrupt, 2 abort
	task automatic wt(input int sel);
		n = 0;
		do begin
			@(posedge ref_clk) #1;
			n++;
		end while (ev[sel] !== 1'b1 && n < 700);
		chk(64'(ev[sel]), 64'h1);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ========
	// main sequence: register access, then five samples
	initial begin
		logic [63:0] e;
		void'($urandom(19655));
		{rst_n, msr_rd, msr_wr, slow, do_abort} = 5'h00;
		msr_idx = 3'h0;
		msr_wdata = 64'h0;
		repeat (16) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (int i = 2; i < 8; i++) begin
			v = {$urandom, $urandom} & ~64'h2;
			wr(3'(i), v);
			e = i > 5 ? 64'h0 : v;
			if (i == 2) e &= esc_pkg::DC_WRITE_MASK;
			if (i == 4) e[63:52] = 12'h000;
			rd(3'(i));
			chk(d, e);
		end
		for (int k = 0; k < 5; k++) begin
			slow = 1'(k);
			do_abort = k == 2;
			wr(3'h0, {44'h0, k == 4, 19'h2_0008});
			wt(0);
			// the model latches the abort choice one edge after the tag
			@(posedge ref_clk) #1 do_abort = 1'b0;
			if (k == 2) begin
				wt(0);
				chk(64'(n < 150), 64'h1);
				rd(3'h2);
				chk(d, exp_r[2]);
			end
			wt(1);
			for (int i = 1; i < 6; i++) begin
				rd(3'(i));
				chk(d, exp_r[i]);
			end
			rd(3'h0);
			chk(64'(d[18:17]), 64'h3);
			// a held sample freezes the interval count
			v = d;
			rd(3'h0);
			chk(d, v);
		end
		wrap_up;
	end
	// watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		wrap_up;
	end
endmodule
